// File: e3_g832_rx_overhead_monitor.v
// Receive overhead monitor for G.832 framed E3 with AHB-Lite registers
//
// Summary of operation
// R1: Payload type field is integrated maintenance byte bits three to five.
// R2: With extraction on, timing field holds four integrated indicator bits.
// R3: With extraction off, timing top bit is zero, low three integrated.
// R4: Integrated general channel byte sits in capture register bits 15:8.
// R5: Integrated network requirement byte sits in capture bits 7:0.
// R6: Framing error events are counted and shown as a 16-bit value.
// R7: Parity errors are counted and shown as a 16-bit value.
// R8: Remote error indications are counted and shown as a 16-bit value.
// R9: Visible error counters change only on the monitor update strobe.
// R10: A parity error sets the latched parity error status bit.
// R11: A remote error indication sets the latched remote error bit.
// R12: An overhead field updates after repeating over consecutive frames.
// R13: Update moves accumulators to counters, saturated, restarting at zero, or at one with an error event in the same cycle.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "e3_g832_regs.vh"

module e3_g832_rx_overhead_monitor (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire frame_strobe,
    input wire [7:0] ma_byte,
    input wire [7:0] nr_byte,
    input wire [7:0] gc_byte,
    input wire framing_error,
    input wire parity_error,
    input wire remote_error,
    input wire perf_monitor_update,
    output reg irq
);

// Compare a word index with a register index
function addr_is;
    input [9:0] idx;
    input [9:0] target;
    begin
        addr_is = (idx == target);
    end
endfunction

// Data phase kinds of the register bus
localparam [1:0] PH_IDLE = 2'h0;
localparam [1:0] PH_WRITE = 2'h1;
localparam [1:0] PH_READ = 2'h2;

// Bus state
reg [1:0] phase_reg;
reg [1:0] phase_next;
reg [9:0] wr_idx_reg;
wire [9:0] bus_idx;
wire bus_take;
wire wr_phase;
wire ctrl_wr;
wire mask_wr;
wire status_wr;

// Control, status and mask
reg ti_extract_reg;
reg [`ST_WIDTH-1:0] status_reg;
reg [`ST_WIDTH-1:0] status_next;
reg [`ST_WIDTH-1:0] mask_reg;
wire irq_next;
reg [`ST_WIDTH-1:0] event_vec;

// Timing indicator assembly
reg [3:0] ssm_word_reg;
reg [3:0] ssm_word_next;
reg [3:0] ti_sample;
reg ti_valid;
wire [1:0] ssm_pos;

// Integrated fields
wire [2:0] payload_type_field;
wire [3:0] timing_source_indication;
wire [7:0] network_requirement_byte;
wire [7:0] general_channel_byte;
wire payload_changed;
wire timing_changed;
wire nr_changed;
wire gc_changed;

// Error counters
wire [2:0] err_events;
wire [47:0] err_counts;
wire [15:0] framing_error_count;
wire [15:0] parity_error_count;
wire [15:0] remote_error_count;

// Read mux
reg [15:0] rd_value;
reg [`ST_WIDTH-1:0] clear_bits;

// Address phase qualification
assign bus_idx = haddr[11:2];
assign bus_take = hsel && hready && htrans == `HTRANS_NONSEQ;

// Next data phase from the address phase now on the bus
always @*
begin
    case ({bus_take, hwrite})
        2'h3:
            phase_next = PH_WRITE;
        2'h2:
            phase_next = PH_READ;
        default:
            phase_next = PH_IDLE;
    endcase
end

// Register write strobes in the data phase
assign wr_phase = phase_reg == PH_WRITE;
assign ctrl_wr = wr_phase && addr_is(wr_idx_reg, `IDX_CONTROL);
assign mask_wr = wr_phase && addr_is(wr_idx_reg, `IDX_IRQ_MASK);
assign status_wr = wr_phase && addr_is(wr_idx_reg, `IDX_IRQ_STATUS);

// Bits six and seven of the maintenance byte give the multiframe slot
assign ssm_pos = ma_byte[2:1];

// Timing indicator source selection
always @*
begin
    ssm_word_next = ssm_word_reg;
    ssm_word_next[~ssm_pos] = ma_byte[0]; // Slot 0 fills bit 3
    if (ti_extract_reg)
    begin
        ti_sample = ssm_word_next; // [R2]
        ti_valid = frame_strobe && ssm_pos == 2'h3;
    end
    else
    begin
        ti_sample = {1'b0, ma_byte[2:0]}; // [R3]
        ti_valid = frame_strobe;
    end
end

// Indicator bits are gathered one per frame
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        ssm_word_reg <= 4'h0;
    else if (frame_strobe && ti_extract_reg)
        ssm_word_reg <= ssm_word_next;
end

// Payload type from maintenance byte bits three to five
field_integrator #(
    .WIDTH(3)
) u_payload_type (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_valid(frame_strobe),
    .sample(ma_byte[5:3]), // [R1]
    .value_reg(payload_type_field),
    .changed_reg(payload_changed)
);

// Timing source indication
field_integrator #(
    .WIDTH(4)
) u_timing_source (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_valid(ti_valid),
    .sample(ti_sample), // [R2] [R3]
    .value_reg(timing_source_indication),
    .changed_reg(timing_changed)
);

// Network requirement byte
field_integrator #(
    .WIDTH(8)
) u_nr_byte (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_valid(frame_strobe),
    .sample(nr_byte), // [R5]
    .value_reg(network_requirement_byte),
    .changed_reg(nr_changed)
);

// General channel byte
field_integrator #(
    .WIDTH(8)
) u_gc_byte (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_valid(frame_strobe),
    .sample(gc_byte), // [R4]
    .value_reg(general_channel_byte),
    .changed_reg(gc_changed)
);

// Error event order: framing, parity, remote
assign err_events = {remote_error, parity_error, framing_error};

// One accumulator and snapshot counter per error kind
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_err
        error_accumulator u_acc (
            .hclk(hclk),
            .hresetn(hresetn),
            .error_event(err_events[gi]), // [R6] [R7] [R8]
            .update(perf_monitor_update), // [R9]
            .count_reg(err_counts[16*gi +: 16])
        );
    end
endgenerate

assign framing_error_count = err_counts[15:0]; // [R6]
assign parity_error_count = err_counts[31:16]; // [R7]
assign remote_error_count = err_counts[47:32]; // [R8]

// Events that latch into the interrupt status
always @*
begin
    event_vec = {`ST_WIDTH{1'b0}};
    event_vec[`ST_PARITY] = parity_error; // [R10]
    event_vec[`ST_REMOTE] = remote_error; // [R11]
    event_vec[`ST_FRAMING] = framing_error;
    event_vec[`ST_PAYLOAD] = payload_changed;
    event_vec[`ST_TIMING] = timing_changed;
    event_vec[`ST_NR] = nr_changed;
    event_vec[`ST_GC] = gc_changed;
end

// Write-one-to-clear bits from a status write in its data phase
always @*
begin
    clear_bits = {`ST_WIDTH{1'b0}};
    if (status_wr)
        clear_bits = hwdata[`ST_WIDTH-1:0];
end

// Sticky status; a new event wins over a clear in the same cycle
always @*
begin
    status_next = (status_reg & ~clear_bits) | event_vec; // [R10] [R11]
end

// Interrupt level from the status about to be stored
assign irq_next = |(status_next & mask_reg);

// Status, mask and interrupt output
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        status_reg <= {`ST_WIDTH{1'b0}};
        mask_reg <= `RST_MASK;
        irq <= 1'b0;
    end
    else
    begin
        status_reg <= status_next;
        if (mask_wr)
            mask_reg <= hwdata[`ST_WIDTH-1:0];
        irq <= irq_next;
    end
end

// Control register: timing indicator extraction enable
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        ti_extract_reg <= `RST_CONTROL;
    else if (ctrl_wr)
        ti_extract_reg <= hwdata[`CTRL_TI_EXTRACT];
end

// Read value selected from the address phase index
always @*
begin
    rd_value = 16'h0000;
    case (bus_idx)
        `IDX_MA_FIELDS:
        begin
            rd_value[`PT_MSB:`PT_LSB] = payload_type_field; // [R1]
            rd_value[`TI_MSB:`TI_LSB] = timing_source_indication; // [R2] [R3]
        end
        `IDX_OVH_CAPTURE:
        begin
            rd_value[`GC_MSB:`GC_LSB] = general_channel_byte; // [R4]
            rd_value[`NR_MSB:`NR_LSB] = network_requirement_byte; // [R5]
        end
        `IDX_FRAMING_CNT:
            rd_value = framing_error_count; // [R6]
        `IDX_PARITY_CNT:
            rd_value = parity_error_count; // [R7]
        `IDX_REMOTE_CNT:
            rd_value = remote_error_count; // [R8]
        `IDX_CONTROL:
            rd_value[`CTRL_TI_EXTRACT] = ti_extract_reg;
        `IDX_IRQ_STATUS:
            rd_value[`ST_WIDTH-1:0] = status_reg;
        `IDX_IRQ_MASK:
            rd_value[`ST_WIDTH-1:0] = mask_reg;
        default:
            rd_value = 16'h0000; // Unmapped words read as zero
    endcase
end

// AHB-Lite slave: zero wait states, always OKAY
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        phase_reg <= PH_IDLE;
        wr_idx_reg <= 10'h000;
        hrdata <= 32'h00000000;
        hreadyout <= 1'b0;
        hresp <= 1'b0;
    end
    else
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (hready)
        begin
            phase_reg <= phase_next;
            wr_idx_reg <= bus_idx;
            if (phase_next == PH_READ)
                hrdata <= {16'h0000, rd_value};
            else
                hrdata <= 32'h00000000;
        end
    end
end

endmodule // e3_g832_rx_overhead_monitor

// File: e3_g832_regs.vh
// Register indices, field positions, reset values and timing counts
`ifndef E3_G832_REGS_VH
`define E3_G832_REGS_VH

// Register indices; byte address is four times the index
`define IDX_MA_FIELDS 10'h130
`define IDX_OVH_CAPTURE 10'h132
`define IDX_FRAMING_CNT 10'h134
`define IDX_PARITY_CNT 10'h136
`define IDX_REMOTE_CNT 10'h138
`define IDX_CONTROL 10'h13A
`define IDX_IRQ_STATUS 10'h13C
`define IDX_IRQ_MASK 10'h13E

// Maintenance field register layout
`define PT_MSB 6
`define PT_LSB 4
`define TI_MSB 3
`define TI_LSB 0

// Overhead capture layout
`define GC_MSB 15
`define GC_LSB 8
`define NR_MSB 7
`define NR_LSB 0

// Control bits
`define CTRL_TI_EXTRACT 0

// Interrupt status bit positions
`define ST_PARITY 0
`define ST_REMOTE 1
`define ST_FRAMING 2
`define ST_PAYLOAD 3
`define ST_TIMING 4
`define ST_NR 5
`define ST_GC 6
`define ST_WIDTH 7

// Reset values
`define RST_CONTROL 1'h0
`define RST_MASK 7'h00
`define RST_COUNT 16'h0000

// Frames a new overhead value must repeat before it is accepted
`define INTEG_FRAMES 3'h3

// Counter saturation value
`define COUNT_MAX 16'hFFFF

// AHB transfer type with a real transfer
`define HTRANS_NONSEQ 2'h2

`endif

// File: field_integrator.v
// Integrates one overhead field over consecutive identical frames
`timescale 1ns/1ns
`include "e3_g832_regs.vh"

module field_integrator #(
    parameter WIDTH = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire sample_valid,
    input wire [WIDTH-1:0] sample,
    output reg [WIDTH-1:0] value_reg,
    output reg changed_reg
);

reg [WIDTH-1:0] cand_reg;
reg [2:0] run_reg;
reg [2:0] run_next;

// Run length of the current candidate, saturating at the threshold
always @*
begin
    if (sample == cand_reg)
        run_next = (run_reg == `INTEG_FRAMES) ? run_reg : run_reg + 3'h1;
    else
        run_next = 3'h1;
end

// Accept a value only after it repeats in enough consecutive frames
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        cand_reg <= {WIDTH{1'b0}};
        run_reg <= 3'h0;
        value_reg <= {WIDTH{1'b0}};
        changed_reg <= 1'b0;
    end
    else
    begin
        changed_reg <= 1'b0;
        if (sample_valid)
        begin
            cand_reg <= sample;
            run_reg <= run_next;
            if (run_next == `INTEG_FRAMES && sample != value_reg)
            begin
                value_reg <= sample; // [R12]
                changed_reg <= 1'b1;
            end
        end
    end
end

endmodule // field_integrator

// File: error_accumulator.v
// Error event accumulator with a snapshot counter on update strobe
`timescale 1ns/1ns
`include "e3_g832_regs.vh"

module error_accumulator (
    input wire hclk,
    input wire hresetn,
    input wire error_event,
    input wire update,
    output reg [15:0] count_reg
);

reg [15:0] acc_reg;

// Saturating accumulation; snapshot and restart on update
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        acc_reg <= `RST_COUNT;
        count_reg <= `RST_COUNT;
    end
    else if (update)
    begin
        count_reg <= acc_reg; // [R9] [R13]
        acc_reg <= error_event ? 16'h0001 : 16'h0000; // [R13]
    end
    else if (error_event && acc_reg != `COUNT_MAX)
        acc_reg <= acc_reg + 16'h0001;
end

endmodule // error_accumulator

// File: e3_g832_rx_overhead_monitor_assertions.sv
// Bus, interrupt and counter checks for the overhead monitor
`timescale 1ns/1ns
`include "e3_g832_regs.vh"
module e3_g832_rx_overhead_monitor_assertions (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire frame_strobe,
    input wire framing_error,
    input wire parity_error,
    input wire remote_error,
    input wire perf_monitor_update,
    input wire irq
);
    reg rd_dp;
    reg wr_dp;
    reg pmu_d;
    reg pmu_s;
    reg [9:0] idx;
    reg [9:0] lidx;
    reg [15:0] last;
    wire take = hsel && hready && htrans == `HTRANS_NONSEQ;
    wire cnt = idx >= `IDX_FRAMING_CNT && idx <= `IDX_REMOTE_CNT;

    // Data phases and the last counter value read
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_dp <= 1'b0;
            wr_dp <= 1'b0;
            pmu_d <= 1'b0;
            pmu_s <= 1'b0;
            idx <= 10'h000;
            lidx <= 10'h000;
            last <= 16'h0000;
        end
        else
        begin
            rd_dp <= take && !hwrite;
            wr_dp <= take && hwrite;
            pmu_d <= perf_monitor_update;
            if (take)
                idx <= haddr[11:2];
            if (rd_dp && cnt)
            begin
                last <= hrdata[15:0];
                lidx <= idx;
                pmu_s <= perf_monitor_update || pmu_d; // Late strobe kept
            end
            else if (perf_monitor_update)
                pmu_s <= 1'b1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    chk_ready_up: assert property ($past(hresetn) |-> hreadyout)
        else $error("slave not ready");
    chk_rdata_idle: assert property (!rd_dp |-> hrdata == 32'h00000000)
        else $error("read data outside read");
    chk_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (rd_dp && idx[0] |-> hrdata == 32'h0)
        else $error("unmapped word not zero");
    chk_ma_layout: assert property (rd_dp && idx == `IDX_MA_FIELDS
        |-> hrdata[15:7] == 9'h000) else $error("spare field bits set");
    chk_cnt_hold: assert property (rd_dp && cnt && idx == lidx && !pmu_s
        |-> hrdata[15:0] == last) else $error("counter moved");
    chk_irq_rise: assert property ($rose(irq) |-> $past(wr_dp, 2)
        || $past(frame_strobe, 2)
        || $past(parity_error || remote_error || framing_error
        || wr_dp)) else $error("interrupt without cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(wr_dp)
        || $past(wr_dp, 2)) else $error("interrupt dropped alone");
endmodule // e3_g832_rx_overhead_monitor_assertions

bind e3_g832_rx_overhead_monitor
    e3_g832_rx_overhead_monitor_assertions u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .frame_strobe(frame_strobe),
    .framing_error(framing_error),
    .parity_error(parity_error),
    .remote_error(remote_error),
    .perf_monitor_update(perf_monitor_update),
    .irq(irq)
);

// File: e3_line_source.sv
// Incoming line model: frame overhead bytes and error pulses
`timescale 1ns/1ns
module e3_line_source (
    input wire hclk,
    output reg frame_strobe = 1'b0,
    output reg [7:0] ma_byte = 8'h00,
    output reg [7:0] nr_byte = 8'h00,
    output reg [7:0] gc_byte = 8'h00,
    output reg framing_error = 1'b0,
    output reg parity_error = 1'b0,
    output reg remote_error = 1'b0,
    output reg perf_monitor_update = 1'b0
);
    // One frame; bytes are only valid with the strobe
    task frame(input [7:0] ma, input [7:0] nr, input [7:0] gc, input int gap);
        @(posedge hclk);
        frame_strobe <= 1'b1;
        ma_byte <= ma;
        nr_byte <= nr;
        gc_byte <= gc;
        @(posedge hclk);
        frame_strobe <= 1'b0;
        ma_byte <= ~ma; // Stale bytes never look valid
        nr_byte <= ~nr;
        gc_byte <= ~gc;
        repeat (gap) @(posedge hclk);
    endtask

    // One-cycle pulses: update, remote, parity, framing
    task pulse(input [3:0] k);
        @(posedge hclk);
        {perf_monitor_update, remote_error, parity_error, framing_error} <= k;
        @(posedge hclk);
        {perf_monitor_update, remote_error, parity_error, framing_error} <= 4'h0;
    endtask
endmodule // e3_line_source

// File: test_e3_g832_rx_overhead_monitor.sv
// Self-checking bench for the receive overhead monitor
`timescale 1ns/1ns
`include "e3_g832_regs.vh"
module test_e3_g832_rx_overhead_monitor;
    reg hclk;
    reg hresetn;
    reg hsel;
    reg [31:0] haddr;
    reg [1:0] htrans;
    reg hwrite;
    reg [2:0] hsize;
    reg [31:0] hwdata;
    reg [31:0] q;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, frame_strobe;
    wire [7:0] ma_byte, nr_byte, gc_byte;
    wire framing_error, parity_error, remote_error, perf_monitor_update;
    int err_total = 0;
    int tests_run = 0;

    // Clock at 100 MHz
    always #5 hclk = ~hclk;

    e3_g832_rx_overhead_monitor u_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .frame_strobe(frame_strobe),
        .ma_byte(ma_byte),
        .nr_byte(nr_byte),
        .gc_byte(gc_byte),
        .framing_error(framing_error),
        .parity_error(parity_error),
        .remote_error(remote_error),
        .perf_monitor_update(perf_monitor_update),
        .irq(irq)
    );

    e3_line_source u_line (
        .hclk(hclk),
        .frame_strobe(frame_strobe),
        .ma_byte(ma_byte),
        .nr_byte(nr_byte),
        .gc_byte(gc_byte),
        .framing_error(framing_error),
        .parity_error(parity_error),
        .remote_error(remote_error),
        .perf_monitor_update(perf_monitor_update)
    );

    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Wait for an edge with ready high, bounded
    task wt;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 100)
            begin
                err_total++;
                $display("mismatch at %0t: bus hang", $time);
                complete_run;
            end
            @(posedge hclk);
        end
    endtask

    // One single AHB transfer; read data lands in q
    task ahb(input w, input [9:0] i, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, i, 2'h0};
        htrans <= `HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wt;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task rc(input [9:0] i, input [31:0] e);
        ahb(1'b0, i, 32'h0);
        chk(q, e);
    endtask

    task t_reset;
        rc(`IDX_MA_FIELDS, 32'h0);
        rc(`IDX_OVH_CAPTURE, 32'h0);
        rc(`IDX_FRAMING_CNT, 32'h0);
        rc(`IDX_REMOTE_CNT, 32'h0);
        rc(`IDX_CONTROL, 32'h0);
        rc(`IDX_IRQ_MASK, 32'h0);
        ahb(1'b1, 10'h131, 32'hFFFF);
        rc(10'h131, 32'h0);
        ahb(1'b1, `IDX_PARITY_CNT, 32'h1234);
        rc(`IDX_PARITY_CNT, 32'h0);
        $display("t_reset done");
    endtask

    task t_ovh;
        u_line.frame(8'h2D, 8'h5A, 8'hC3, 0);
        u_line.frame(8'h2D, 8'h5A, 8'hC3, 3);
        rc(`IDX_OVH_CAPTURE, 32'h0);
        u_line.frame(8'h2D, 8'h5A, 8'hC3, 1);
        rc(`IDX_OVH_CAPTURE, 32'hC35A);
        rc(`IDX_MA_FIELDS, 32'h55);
        $display("t_ovh done");
    endtask

    // Extraction on: indicator 1010 spread over four frames
    task t_ti;
        int r;
        int s;
        ahb(1'b1, `IDX_CONTROL, 32'h1);
        for (r = 0; r < 3; r++)
            for (s = 0; s < 4; s++)
                u_line.frame({5'h05, s[1:0], ~s[0]}, 8'h5A, 8'hC3, 0);
        rc(`IDX_MA_FIELDS, 32'h5A);
        $display("t_ti done");
    endtask

    task t_cnt;
        rc(`IDX_PARITY_CNT, 32'h0);
        repeat (3) u_line.pulse(4'h2);
        repeat (2) u_line.pulse(4'h4);
        u_line.pulse(4'h1);
        rc(`IDX_PARITY_CNT, 32'h0);
        u_line.pulse(4'hA);
        rc(`IDX_FRAMING_CNT, 32'h1);
        rc(`IDX_PARITY_CNT, 32'h3);
        rc(`IDX_REMOTE_CNT, 32'h2);
        u_line.pulse(4'h8);
        rc(`IDX_PARITY_CNT, 32'h1);
        rc(`IDX_REMOTE_CNT, 32'h0);
        $display("t_cnt done");
    endtask

    // Write then let irq settle before looking
    task wirq(input [9:0] i, input [31:0] d, input e);
        ahb(1'b1, i, d);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task t_irq;
        rc(`IDX_IRQ_STATUS, 32'h7F);
        wirq(`IDX_IRQ_MASK, 32'h1, 1'b1);
        wirq(`IDX_IRQ_STATUS, 32'h7F, 1'b0);
        u_line.pulse(4'h4);
        rc(`IDX_IRQ_STATUS, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wirq(`IDX_IRQ_MASK, 32'h2, 1'b1);
        wirq(`IDX_IRQ_STATUS, 32'h2, 1'b0);
        $display("t_irq done");
    endtask

    initial
    begin
        hclk = 1'b0;
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h00000000;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h0;
        hwdata <= 32'h00000000;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_ovh;
        t_ti;
        t_cnt;
        t_irq;
        complete_run;
    end
endmodule // test_e3_g832_rx_overhead_monitor
